//--- rtl/vip_top.sv
// vectored interrupt prioritizer top level
`timescale 1ns/1ps
`include "vip_defs.svh"
module vip_top
  import vip_pkg::*;
#(
  parameter int NUM_PINS = `VIP_NUM_PINS,
  parameter int EXT3_CH  = `VIP_EXT3_CH
) (
  // clock and reset
  input  wire logic                                clock_in,
  input  wire logic                                rst_in,
  // peripheral requests
  input  wire logic [`VIP_NUM_CH-1:0]              irq_src_in,
  // port 0 and port 2 pads
  input  wire logic [`VIP_PORT_W-1:0]              port0_pin_in,
  input  wire logic [`VIP_PORT_W-1:0]              port2_pin_in,
  // channel configuration
  input  wire logic [`VIP_NUM_CH-1:0]              enable_in,
  input  wire logic [`VIP_NUM_CH-1:0]              fast_sel_in,
  input  wire logic [`VIP_NUM_CH*`VIP_PRIO_W-1:0]  priority_in,
  input  wire logic [`VIP_NUM_CH*`VIP_ADDR_W-1:0]  vector_addr_in,
  input  wire logic [`VIP_ADDR_W-1:0]              default_addr_in,
  // pin edge configuration
  input  wire logic [NUM_PINS-1:0]                 edge_rise_en_in,
  input  wire logic [NUM_PINS-1:0]                 edge_fall_en_in,
  input  wire logic [NUM_PINS-1:0]                 edge_clear_in,
  // core side
  output logic                                     fast_interrupt_request_out,
  output logic                                     normal_irq_out,
  // readable state
  output logic [`VIP_NUM_CH-1:0]                   fast_status_out,
  output logic [`VIP_ADDR_W-1:0]                   vector_addr_out,
  output logic [`VIP_CH_W-1:0]                     vector_chan_out,
  output logic                                     vector_valid_out,
  output logic [NUM_PINS-1:0]                      edge_pending_out,
  output logic                                     external_interrupt_line_3_out
);

  // ****************************************
  // pin edge detector
  // ****************************************
  vip_edge_if #(.NUM_PINS(NUM_PINS)) edge_bus ();

  assign edge_bus.rise_en = edge_rise_en_in;
  assign edge_bus.fall_en = edge_fall_en_in;
  assign edge_bus.clear   = edge_clear_in;

  vip_edge_detect #(
    .NUM_PINS (NUM_PINS)
  ) u_edge (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .pin_in   ({port2_pin_in, port0_pin_in}),
    .edge_bus (edge_bus)
  );

  // ****************************************
  // request gathering
  // ****************************************
  function automatic vip_prio_t vip_prio_of(input logic [`VIP_NUM_CH*`VIP_PRIO_W-1:0] tbl,
                                            input int ch);
    return tbl[ch*`VIP_PRIO_W +: `VIP_PRIO_W];
  endfunction : vip_prio_of

  // lowest value is most urgent; strict compare keeps the lower channel on ties
  function automatic vip_sel_s vip_pick(input logic [`VIP_NUM_CH-1:0]             act,
                                        input logic [`VIP_NUM_CH*`VIP_PRIO_W-1:0] tbl);
    vip_sel_s best;
    best = '0;
    for (int i = 0; i < `VIP_NUM_CH; i++) begin
      if (act[i] && (!best.valid || vip_prio_of(tbl, i) < best.prio)) begin
        best.valid = 1'b1;
        best.chan  = i[`VIP_CH_W-1:0];
        best.prio  = vip_prio_of(tbl, i);
      end
    end
    return best;
  endfunction : vip_pick

  logic [`VIP_NUM_CH-1:0] merged_req;
  logic [`VIP_NUM_CH-1:0] active;
  logic [`VIP_NUM_CH-1:0] active_fast;
  logic [`VIP_NUM_CH-1:0] active_vec;
  vip_sel_s               pick;

  always_comb begin
    merged_req          = irq_src_in;
    merged_req[EXT3_CH] = irq_src_in[EXT3_CH] | edge_bus.merged;
    active              = merged_req & enable_in;
    active_fast         = active & fast_sel_in;
    active_vec          = active & ~fast_sel_in;
    // fast channels never compete for the vector
    pick                = vip_pick(active_vec, priority_in);
  end

  // ****************************************
  // output registers
  // ****************************************
  logic                   fast_reg;
  logic                   fast_next;
  logic                   normal_reg;
  logic                   normal_next;
  logic [`VIP_NUM_CH-1:0] fast_status_reg;
  logic [`VIP_NUM_CH-1:0] fast_status_next;
  vip_addr_t              vec_addr_reg;
  vip_addr_t              vec_addr_next;
  vip_chan_t              vec_chan_reg;
  vip_chan_t              vec_chan_next;
  logic                   vec_valid_reg;
  logic                   vec_valid_next;

  always_comb begin
    fast_next        = |active_fast;
    normal_next      = |active_vec;
    fast_status_next = active_fast;
    vec_valid_next   = pick.valid;
    vec_chan_next    = pick.valid ? pick.chan : '0;
    vec_addr_next    = pick.valid ? vector_addr_in[pick.chan*`VIP_ADDR_W +: `VIP_ADDR_W]
                                  : default_addr_in;
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      fast_reg        <= 1'b0;
      normal_reg      <= 1'b0;
      fast_status_reg <= '0;
      vec_addr_reg    <= `VIP_ADDR_RST;
      vec_chan_reg    <= '0;
      vec_valid_reg   <= 1'b0;
    end else begin
      fast_reg        <= fast_next;
      normal_reg      <= normal_next;
      fast_status_reg <= fast_status_next;
      vec_addr_reg    <= vec_addr_next;
      vec_chan_reg    <= vec_chan_next;
      vec_valid_reg   <= vec_valid_next;
    end
  end

  assign fast_interrupt_request_out    = fast_reg;
  assign normal_irq_out                = normal_reg;
  assign fast_status_out               = fast_status_reg;
  assign vector_addr_out               = vec_addr_reg;
  assign vector_chan_out               = vec_chan_reg;
  assign vector_valid_out              = vec_valid_reg;
  assign edge_pending_out              = edge_bus.pending;
  assign external_interrupt_line_3_out = merged_req[EXT3_CH];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // helper: a strictly better or equal-and-lower rival to the chosen channel
  logic [`VIP_NUM_CH-1:0] prev_vec_reg;
  logic [`VIP_NUM_CH*`VIP_PRIO_W-1:0] prev_prio_reg;
  logic [`VIP_NUM_CH-1:0]             prev_fsel_reg;
  logic [`VIP_NUM_CH*`VIP_ADDR_W-1:0] prev_addr_reg;
  logic                   rival;

  // inputs as seen at the edge that loaded the vector registers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      prev_vec_reg  <= '0;
      prev_prio_reg <= '0;
      prev_fsel_reg <= '0;
      prev_addr_reg <= '0;
    end else begin
      prev_vec_reg  <= active_vec;
      prev_prio_reg <= priority_in;
      prev_fsel_reg <= fast_sel_in;
      prev_addr_reg <= vector_addr_in;
    end
  end

  always_comb begin
    rival = 1'b0;
    for (int i = 0; i < `VIP_NUM_CH; i++) begin
      if (prev_vec_reg[i] && (vip_prio_of(prev_prio_reg, i) < vip_prio_of(prev_prio_reg,
          int'(vec_chan_reg)) || (vip_prio_of(prev_prio_reg, i) == vip_prio_of(prev_prio_reg,
          int'(vec_chan_reg)) && i < int'(vec_chan_reg)))) begin
        rival = 1'b1;
      end
    end
  end

  sequence fast_seen_s;
    (active_fast != '0);
  endsequence

  sequence vec_seen_s;
    (active_vec != '0);
  endsequence

  fast_or_a: assert property (fast_seen_s |=> fast_interrupt_request_out)
    else $error("fast output missing for active fast request");
  fast_idle_a: assert property (!(active_fast != '0) |=> !fast_interrupt_request_out)
    else $error("fast output raised with no fast request");
  fast_word_a: assert property (##1 fast_status_out == $past(active_fast))
    else $error("fast status word does not match requests");
  normal_or_a: assert property (vec_seen_s |=> normal_irq_out && vector_valid_out)
    else $error("normal output missing for vectored request");
  fast_excl_a: assert property (vector_valid_out |->
      !prev_fsel_reg[vector_chan_out])
    else $error("fast channel won the vector");
  tie_low_a: assert property (vector_valid_out |-> !rival)
    else $error("vector chose a worse or higher channel");
  vec_addr_a: assert property (vector_valid_out |->
      vector_addr_out == prev_addr_reg[vector_chan_out*`VIP_ADDR_W +: `VIP_ADDR_W])
    else $error("vector address does not match chosen channel");
  enable_gate_a: assert property ((enable_in == '0) |=>
      !fast_interrupt_request_out && !normal_irq_out && fast_status_out == '0)
    else $error("disabled inputs reached the core");
  merge_ext3_a: assert property ((edge_bus.pending != '0) |->
      external_interrupt_line_3_out)
    else $error("pending pin edge not merged into line 3");
  reprio_a: assert property (vec_seen_s and $changed(priority_in) |=>
      vector_valid_out && !rival)
    else $error("priority change not followed");
endmodule : vip_top

//--- rtl/vip_defs.svh
// constants of the vectored interrupt prioritizer
`ifndef VIP_DEFS_SVH
`define VIP_DEFS_SVH

// ****************************************
// sizes
// ****************************************
`define VIP_NUM_CH      32
`define VIP_CH_W        5
`define VIP_PRIO_W      4
`define VIP_ADDR_W      32
`define VIP_NUM_PINS    64
`define VIP_PORT_W      32

// ****************************************
// field positions and reset values
// ****************************************
`define VIP_EXT3_CH     17
`define VIP_ADDR_RST    32'h0000_0000
`define VIP_PRIO_RST    4'h0
`define VIP_PRIME_CNT   2'h3

`endif

//--- rtl/vip_pkg.sv
// types of the vectored interrupt prioritizer
`include "vip_defs.svh"
package vip_pkg;
  typedef logic [`VIP_PRIO_W-1:0] vip_prio_t;
  typedef logic [`VIP_CH_W-1:0]   vip_chan_t;
  typedef logic [`VIP_ADDR_W-1:0] vip_addr_t;

  typedef struct packed {
    logic      valid;
    vip_chan_t chan;
    vip_prio_t prio;
  } vip_sel_s;
endpackage : vip_pkg

//--- rtl/vip_edge_if.sv
// link between the prioritizer and its pin edge detector
`timescale 1ns/1ps
`include "vip_defs.svh"
interface vip_edge_if #(
  parameter int NUM_PINS = `VIP_NUM_PINS
);
  logic [NUM_PINS-1:0] rise_en;
  logic [NUM_PINS-1:0] fall_en;
  logic [NUM_PINS-1:0] clear;
  logic [NUM_PINS-1:0] pending;
  logic                merged;

  modport ctrl (output rise_en, output fall_en, output clear, input pending, input merged);
  modport det  (input rise_en, input fall_en, input clear, output pending, output merged);
endinterface : vip_edge_if

//--- rtl/vip_edge_detect.sv
// pin edge detector with sticky pending flags
`timescale 1ns/1ps
`include "vip_defs.svh"
module vip_edge_detect
  import vip_pkg::*;
#(
  parameter int NUM_PINS = `VIP_NUM_PINS
) (
  // clock and reset
  input  wire logic                clock_in,
  input  wire logic                rst_in,
  // raw pads
  input  wire logic [NUM_PINS-1:0] pin_in,
  // control side
  vip_edge_if.det                  edge_bus
);

  // ****************************************
  // synchroniser and edge memory
  // ****************************************
  logic [NUM_PINS-1:0] sync1_reg;
  logic [NUM_PINS-1:0] sync2_reg;
  logic [NUM_PINS-1:0] last_reg;
  logic [NUM_PINS-1:0] last_next;
  logic [NUM_PINS-1:0] pending_reg;
  logic [NUM_PINS-1:0] pending_next;
  logic [1:0]          prime_reg;
  logic [1:0]          prime_next;
  logic [NUM_PINS-1:0] rise;
  logic [NUM_PINS-1:0] fall;
  logic [NUM_PINS-1:0] hit;

  always_comb begin
    last_next  = sync2_reg;
    prime_next = (prime_reg == `VIP_PRIME_CNT) ? prime_reg : prime_reg + 2'h1;
    // no edges until the chain holds real pad levels
    rise       = (prime_reg == `VIP_PRIME_CNT) ? (sync2_reg & ~last_reg) : '0;
    fall       = (prime_reg == `VIP_PRIME_CNT) ? (~sync2_reg & last_reg) : '0;
    hit        = (rise & edge_bus.rise_en) | (fall & edge_bus.fall_en);
    // set beats clear in the same cycle
    pending_next = (pending_reg & ~edge_bus.clear) | hit;
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_reg   <= '0;
      sync2_reg   <= '0;
      last_reg    <= '0;
      pending_reg <= '0;
      prime_reg   <= 2'h0;
    end else begin
      sync1_reg   <= pin_in;
      sync2_reg   <= sync1_reg;
      last_reg    <= last_next;
      pending_reg <= pending_next;
      prime_reg   <= prime_next;
    end
  end

  assign edge_bus.pending = pending_reg;
  assign edge_bus.merged  = |pending_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  pending_hold_a: assert property ((pending_reg & ~edge_bus.clear) != '0 |=>
      ((pending_reg & $past(pending_reg & ~edge_bus.clear)) == $past(pending_reg & ~edge_bus.clear)))
    else $error("pending flag dropped without clear");
  rise_set_a: assert property ((rise & edge_bus.rise_en) != '0 |=>
      ((pending_reg & $past(rise & edge_bus.rise_en)) == $past(rise & edge_bus.rise_en)))
    else $error("rising edge not latched");
  fall_set_a: assert property ((fall & edge_bus.fall_en) != '0 |=>
      ((pending_reg & $past(fall & edge_bus.fall_en)) == $past(fall & edge_bus.fall_en)))
    else $error("falling edge not latched");
endmodule : vip_edge_detect

//--- verification/vip_core_model.sv
// behavioural model of the processor core taking interrupts
`timescale 1ns/1ps
module vip_core_model #(
  parameter int LAT = 3
) (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // requests from the prioritizer
  input  wire logic        fast_irq_in,
  input  wire logic        normal_irq_in,
  input  wire logic [31:0] vector_addr_in,
  // service taken
  output logic             fast_taken_out,
  output logic             normal_taken_out,
  output logic [31:0]      branch_out
);
  logic [3:0] wait_reg;

  // request must hold LAT cycles before the core takes it
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wait_reg         <= 4'h0;
      fast_taken_out   <= 1'b0;
      normal_taken_out <= 1'b0;
      branch_out       <= 32'h0000_0000;
    end else begin
      fast_taken_out   <= 1'b0;
      normal_taken_out <= 1'b0;
      if (!(fast_irq_in || normal_irq_in)) begin
        wait_reg <= 4'h0;
      end else if (wait_reg < LAT[3:0]) begin
        wait_reg <= wait_reg + 4'h1;
      end else if (fast_irq_in) begin
        fast_taken_out <= 1'b1;
      end else begin
        normal_taken_out <= 1'b1;
        branch_out       <= vector_addr_in;
      end
    end
  end
endmodule : vip_core_model

//--- verification/tb.sv
// self-checking bench of the vectored interrupt prioritizer
`timescale 1ns/1ps
`include "vip_defs.svh"
module tb
  import vip_pkg::*;
;
  logic          clock_in = 1'b0;
  logic          rst_in   = 1'b1;
  logic [31:0]   src      = '0;
  logic [31:0]   en       = '0;
  logic [31:0]   fsel     = '0;
  logic [127:0]  prio     = '0;
  logic [1023:0] vaddr;
  logic [63:0]   pads     = '0;
  logic [63:0]   rise     = '0;
  logic [63:0]   fall     = '0;
  logic [63:0]   clr      = '0;
  logic [31:0]   def      = 32'hFFFF_0000;
  logic          fast_irq, irq, ext3, vvalid, ftake, ntake;
  logic [31:0]   fstat, vout, branch;
  logic [4:0]    vchan;
  logic [63:0]   pend;
  int            err_count = 0;
  int            checked   = 0;

  always #50 clock_in = ~clock_in;

  vip_top uut (
    .clock_in(clock_in), .rst_in(rst_in), .irq_src_in(src),
    .port0_pin_in(pads[31:0]), .port2_pin_in(pads[63:32]),
    .enable_in(en), .fast_sel_in(fsel), .priority_in(prio),
    .vector_addr_in(vaddr), .default_addr_in(def),
    .edge_rise_en_in(rise), .edge_fall_en_in(fall), .edge_clear_in(clr),
    .fast_interrupt_request_out(fast_irq), .normal_irq_out(irq),
    .fast_status_out(fstat), .vector_addr_out(vout), .vector_chan_out(vchan),
    .vector_valid_out(vvalid), .edge_pending_out(pend),
    .external_interrupt_line_3_out(ext3)
  );

  vip_core_model #(.LAT(3)) core (
    .clock_in(clock_in), .rst_in(rst_in), .fast_irq_in(fast_irq), .normal_irq_in(irq),
    .vector_addr_in(vout), .fast_taken_out(ftake), .normal_taken_out(ntake),
    .branch_out(branch)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic ticks(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : ticks

  task automatic wait_core(input logic want_fast);
    int i;
    for (i = 0; i < 12; i++) begin
      ticks(1);
      if ((want_fast ? ftake : ntake) === 1'b1) break;
    end
    if (i == 12) begin
      err_count++;
      $display("Error core take expected 1 seen 0");
      finish_test();
    end
  endtask : wait_core

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_vector();
    @(posedge clock_in);
    en           <= 32'h0000_020A;
    src          <= 32'h0000_020A;
    prio[4 +: 4] <= 4'h5;
    prio[12+: 4] <= 4'h2;
    prio[36+: 4] <= 4'h2;
    ticks(1);
    check("tie chan", 5'h03, vchan);
    check("vector addr", vaddr[96 +: 32], vout);
    check("normal", 1'b1, irq);
    wait_core(1'b0);
    check("core branch", vaddr[96 +: 32], branch);
    @(posedge clock_in);
    prio[36 +: 4] <= 4'h1;
    ticks(1);
    check("reprio chan", 5'h09, vchan);
    check("reprio addr", vaddr[288 +: 32], vout);
    @(posedge clock_in);
    en[9] <= 1'b0;
    ticks(1);
    check("disabled chan", 5'h03, vchan);
    @(posedge clock_in);
    src <= '0;
    ticks(1);
    check("idle valid", 1'b0, vvalid);
    check("idle addr", def, vout);
    check("idle normal", 1'b0, irq);
    $display("vector test done");
  endtask : t_vector

  task automatic t_fast();
    @(posedge clock_in);
    en   <= 32'h0010_0028;
    fsel <= 32'h0010_0020;
    src  <= 32'h0010_0028;
    ticks(1);
    check("fast out", 1'b1, fast_irq);
    check("fast status", 32'h0010_0020, fstat);
    check("fast excluded", 5'h03, vchan);
    wait_core(1'b1);
    @(posedge clock_in);
    en[20] <= 1'b0;
    src[3] <= 1'b0;
    ticks(1);
    check("masked status", 32'h0000_0020, fstat);
    check("fast only valid", 1'b0, vvalid);
    check("fast only normal", 1'b0, irq);
    @(posedge clock_in);
    src[5] <= 1'b0;
    ticks(1);
    check("fast off", 1'b0, fast_irq);
    $display("fast test done");
  endtask : t_fast

  task automatic t_edge();
    int   p;
    logic r, f;
    @(posedge clock_in);
    en   <= 32'h0002_0000;
    fsel <= '0;
    for (int m = 0; m < 3; m++) begin
      p = 2 + 20 * m;
      r = (m != 1);
      f = (m != 0);
      @(posedge clock_in);
      rise[p] <= r;
      fall[p] <= f;
      pads[p] <= 1'b1;
      ticks(4);
      check("rise pend", r, pend[p]);
      check("merged line", r, ext3);
      check("merged irq", r, irq);
      @(posedge clock_in);
      clr[p]  <= 1'b1;
      pads[p] <= 1'b0;
      @(posedge clock_in);
      clr[p] <= 1'b0;
      ticks(3);
      check("fall pend", f, pend[p]);
      @(posedge clock_in);
      clr[p] <= 1'b1;
      @(posedge clock_in);
      clr[p] <= 1'b0;
      ticks(1);
      check("cleared", 1'b0, pend[p]);
      check("merged idle", 1'b0, ext3);
    end
    $display("edge test done");
  endtask : t_edge

  initial begin
    for (int c = 0; c < 32; c++) begin
      vaddr[32*c +: 32] = 32'h0000_1000 + 32'h0000_0010 * c;
    end
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    ticks(4);
    t_vector();
    t_fast();
    t_edge();
    finish_test();
  end
endmodule : tb
